// File: bench/rsb_strap_board.sv
// Purpose: board strap model for the strap and priority bank
// Assumes: straps valid through reset and the first cycle after release
// Notes: afterwards the shared pins carry traffic, shown as inverted values
`timescale 1ns/10ps
// ==========================================================================
// module
module rsb_strap_board
(
	input wire logic i_clock, // system clock
	input wire logic i_rst, // device reset
	input wire logic [7:0] i_set, // {endian, fast, pll, mode}
	output logic [2:0] o_pinout_mode_strap, // to device
	output logic [2:0] o_pll_multiplier_strap, // to device
	output logic o_fastboot_strap, // to device
	output logic o_endianness_strap // to device
);
	logic released;
	logic [7:0] pins;
	// release seen one edge late, so the capture cycle still sees straps
	always_ff @(posedge i_clock)
	begin
		released <= !i_rst;
	end
	// straps while held in reset and for one cycle after release, then the pins are reused
	assign pins = (i_rst || !released) ? i_set : ~i_set;
	assign o_pinout_mode_strap = pins[2:0];
	assign o_pll_multiplier_strap = pins[5:3];
	assign o_fastboot_strap = pins[6];
	assign o_endianness_strap = pins[7];
endmodule : rsb_strap_board

// File: bench/rsb_top_tb.sv
// Purpose: self-checking bench for the strap and priority bank
// Assumes: ack one cycle after a request is taken
// Notes: strap values change after capture to prove they are held
`timescale 1ns/10ps
// ==========================================================================
// module
module rsb_top_tb;
	import rsb_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic ack;
	logic [31:0] rdat;
	logic [7:0] straps = 8'h0;
	logic [2:0] s_mode, s_pll, o_mode, o_pll, p_cfg, p_host, p_link, p_eth;
	logic s_fast, s_end, o_little;
	logic [31:0] rd;
	int fails = 0;
	int cmp_count = 0;
	// ======================================================================
	// clock, board and device
	always #12.5 clk = ~clk;
	rsb_strap_board board (.i_clock(clk), .i_rst(rst), .i_set(straps),
		.o_pinout_mode_strap(s_mode), .o_pll_multiplier_strap(s_pll),
		.o_fastboot_strap(s_fast), .o_endianness_strap(s_end));
	rsb_top dut (.i_clock(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.o_wb_ack(ack), .o_wb_dat(rdat), .i_pinout_mode_strap(s_mode),
		.i_pll_multiplier_strap(s_pll), .i_fastboot_strap(s_fast),
		.i_endianness_strap(s_end), .o_pinout_mode(o_mode),
		.o_fastboot_pll_mult(o_pll), .o_little_endian(o_little),
		.o_cpu_config_port_priority(p_cfg), .o_host_port_priority(p_host),
		.o_serial_link_priority(p_link), .o_ethernet_priority(p_eth));
	// ======================================================================
	// tasks
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// one classic cycle; read data taken at the ack edge
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			chk("ack", 32'h0, 32'h1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task automatic rd_chk(input string name, input logic [31:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(name, rd, exp);
	endtask : rd_chk
	task automatic do_reset(input logic [7:0] s);
		@(posedge clk);
		straps <= s;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : do_reset
	// ======================================================================
	// watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end
	// ======================================================================
	// tests
	initial
	begin
		// straps: endian 1, fast 1, pll 6, mode 5
		do_reset(8'hf5);
		chk("pin mode", 32'(o_mode), 32'h5);
		chk("pll out", 32'(o_pll), 32'h6);
		chk("little", 32'(o_little), 32'h1);
		chk("prio out", {20'h0, p_cfg, p_host, p_link, p_eth}, 32'h0324);
		rd_chk("boot", ADDR_BOOT_STATUS, 32'h0365);
		rd_chk("pinsel", ADDR_PIN_SELECT, 32'h5);
		rd_chk("cfg", ADDR_CFG_PRIO, 32'h0100);
		rd_chk("periph", ADDR_PERIPH_PRIO, 32'h04440004);
		$display("test reset values done");
		// status is read-only, pin select is writable
		bus(1'b1, ADDR_BOOT_STATUS, 32'hffffffff, 4'hf);
		rd_chk("boot ro", ADDR_BOOT_STATUS, 32'h0365);
		bus(1'b1, ADDR_PIN_SELECT, 32'h2, 4'hf);
		rd_chk("pinsel wr", ADDR_PIN_SELECT, 32'h2);
		chk("pin mode wr", 32'(o_mode), 32'h2);
		chk("little held", 32'(o_little), 32'h1);
		rd_chk("boot kept", ADDR_BOOT_STATUS, 32'h0365);
		rd_chk("unmapped", 32'h01c40080, 32'h0);
		$display("test status and pin select done");
		// priority registers, reserved bits and byte lanes
		bus(1'b1, ADDR_CFG_PRIO, 32'hffffffff, 4'hf);
		rd_chk("cfg ones", ADDR_CFG_PRIO, 32'h0700);
		chk("cfg out", 32'(p_cfg), 32'h7);
		bus(1'b1, ADDR_PERIPH_PRIO, 32'hfcffffff, 4'hf);
		rd_chk("periph ones", ADDR_PERIPH_PRIO, 32'h04770007);
		bus(1'b1, ADDR_PERIPH_PRIO, 32'h0, 4'h1);
		rd_chk("periph lane", ADDR_PERIPH_PRIO, 32'h04770000);
		chk("eth out", 32'(p_eth), 32'h0);
		chk("link out", 32'(p_link), 32'h7);
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, ADDR_PERIPH_PRIO, 32'h04000000 | (c << 20), 4'hf);
			rd_chk("host code", ADDR_PERIPH_PRIO, 32'h04000000 | (c << 20));
			chk("host out", 32'(p_host), c);
		end
		$display("test priorities done");
		// second reset: fast boot off, big endian, mode 3, pll 5
		do_reset(8'h2b);
		chk("pll off", 32'(o_pll), 32'h0);
		chk("big", 32'(o_little), 32'h0);
		chk("pin mode 2", 32'(o_mode), 32'h3);
		chk("prio out 2", {20'h0, p_cfg, p_host, p_link, p_eth}, 32'h0324);
		rd_chk("boot 2", ADDR_BOOT_STATUS, 32'h0053);
		rd_chk("periph 2", ADDR_PERIPH_PRIO, 32'h04440004);
		$display("test second reset done");
		conclude();
	end
endmodule : rsb_top_tb

// File: hw/rsb_pkg.sv
// Purpose: shared constants for the strap and bus-priority register bank
// Assumes: 32-bit classic wishbone, byte addresses on the bus
// Notes: priority codes are 3 bits, smaller code wins arbitration
// ==========================================================================
// package
package rsb_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_CFG_PRIO = 32'h01c4003c;
	localparam logic [31:0] ADDR_PERIPH_PRIO = 32'h01c40040;
	localparam logic [31:0] ADDR_BOOT_STATUS = 32'h01c40100;
	localparam logic [31:0] ADDR_PIN_SELECT = 32'h01c40104;
	// field widths
	localparam int PRIO_W = 3;
	localparam int MODE_W = 3;
	// cfg_master_priority layout
	localparam int CFG_PRIO_LSB = 8;
	// periph_master_priority layout
	localparam int RSV_PRIO_LSB = 24;
	localparam int HOST_PRIO_LSB = 20;
	localparam int LINK_PRIO_LSB = 16;
	localparam int ETH_PRIO_LSB = 0;
	// boot_status_register layout
	localparam int BOOT_MODE_LSB = 0;
	localparam int BOOT_PLL_LSB = 4;
	localparam int BOOT_ENDIAN_BIT = 8;
	localparam int BOOT_FAST_BIT = 9;
	// pin_select_register layout
	localparam int PINSEL_MODE_LSB = 0;
	// reset values
	localparam logic [2:0] RST_CFG_PRIO = 3'h1;
	localparam logic [2:0] RST_PERIPH_PRIO = 3'h4;
	localparam logic [2:0] RST_RSV_PRIO = 3'h4;
	// priorities owned by other blocks, kept for reference
	localparam logic [2:0] DMA_TC_PRIO_DEFAULT = 3'h0; // R15
	localparam logic [2:0] CPU_DMA_PRIO_DEFAULT = 3'h7; // R15
endpackage : rsb_pkg

// File: hw/rsb_reg_if.sv
// Purpose: register access request between bus slave and register bank
// Assumes: one request is a one-cycle pulse on req
// Notes: rdata answers combinationally in the request cycle
`timescale 1ns/10ps
// ==========================================================================
// interface
interface rsb_reg_if;
	logic req;
	logic we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [3:0] sel;
	logic [31:0] rdata;
	modport slave (output req, we, addr, wdata, sel, input rdata);
	modport bank (input req, we, addr, wdata, sel, output rdata);
endinterface : rsb_reg_if

// File: hw/rsb_strap_latch.sv
// Purpose: captures the board straps at the first clock after reset release
// Assumes: strap inputs are stable around reset release
// Notes: captured values never change until the next reset
`timescale 1ns/10ps
// ==========================================================================
// module
module rsb_strap_latch
	import rsb_pkg::*;
(
	input wire logic i_clock, // system clock
	input wire logic i_rst, // sync reset, active high
	input wire logic [MODE_W-1:0] i_pinout_mode_strap, // pinout strap
	input wire logic [2:0] i_pll_multiplier_strap, // pll strap
	input wire logic i_fastboot_strap, // fast boot strap
	input wire logic i_endianness_strap, // 1 little, 0 big
	output logic o_capture, // pulse in the capture cycle
	output logic [MODE_W-1:0] o_latched_pinout_mode, // held pinout
	output logic [2:0] o_pll_mult, // held pll strap
	output logic o_fastboot, // held fast boot strap
	output logic o_endian // held endianness strap
);
	typedef struct packed {
		logic was_rst;
		logic [MODE_W-1:0] mode;
		logic [2:0] pll;
		logic fast;
		logic endian;
	} rsb_strap_state_t;

	rsb_strap_state_t state;
	rsb_strap_state_t next_state;

	// first cycle with reset low after reset was high
	assign o_capture = state.was_rst && !i_rst;

	// capture once, then hold
	always_comb
	begin
		next_state = state;
		next_state.was_rst = 1'b0;
		if (o_capture)
		begin
			next_state.mode = i_pinout_mode_strap; // R1
			next_state.pll = i_pll_multiplier_strap; // R6
			next_state.fast = i_fastboot_strap;
			next_state.endian = i_endianness_strap; // R8
		end
	end

	// state register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state <= '0;
			state.was_rst <= 1'b1;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign o_latched_pinout_mode = state.mode;
	assign o_pll_mult = state.pll;
	assign o_fastboot = state.fast;
	assign o_endian = state.endian;

	// ==================================================================
	// checks
	chk_pinout_capture: assert property (@(posedge i_clock) disable iff (i_rst) // R1
		o_capture |=> o_latched_pinout_mode == $past(i_pinout_mode_strap))
		else $error("pinout strap not captured at reset release");
	chk_pll_capture: assert property (@(posedge i_clock) disable iff (i_rst) // R6
		o_capture |=> o_pll_mult == $past(i_pll_multiplier_strap))
		else $error("pll strap not captured at reset release");
	chk_straps_hold: assert property (@(posedge i_clock) disable iff (i_rst) // R8
		!o_capture |=> $stable(o_endian) && $stable(o_pll_mult)
			&& $stable(o_latched_pinout_mode))
		else $error("latched strap changed after capture");
endmodule : rsb_strap_latch

// File: hw/rsb_top.sv
// Purpose: strap status, pin select and bus master priority registers
// Assumes: classic wishbone master, straps from the board pins
// Notes: all fabric priority outputs are registered and always valid
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
// ==========================================================================
// module
// What this block does
// R1 - latch the three pinout-mode straps at reset release into boot status
// R2 - latched pinout strap becomes the reset value of the pin select field
// R3 - boot status ignores writes; pin select pinout field is writable
// R4 - pinout mode only steers pin selection, never the memory controller
// R5 - pll multiplier straps count only when fast boot strap is 1
// R6 - pll multiplier straps captured at reset release, read-only
// R7 - endianness strap 1 means little endian, 0 means big endian
// R8 - latched endianness strap reads back and ignores writes
// R9 - priority codes are 3 bits, 000 highest, 111 lowest
// R10 - config port priority resets to 1, ethernet, link and host to 4
// R11 - first priority register: config port priority bits 10:8, reset 001
// R12 - second register: host 22:20, link 18:16, ethernet 2:0, reset 100
// R13 - reserved bits 26:24 reset to 100; software must write 100 there
// R14 - read-only reserved bits of both priority registers read zero
// R15 - dma controller and cpu dma priorities live elsewhere, defaults 0 and 7
// R16 - priority fields drive the fabric arbiter continuously
module rsb_top
	import rsb_pkg::*;
(
	input wire logic i_clock, // system clock, 40 MHz
	input wire logic i_rst, // sync reset, active high
	input wire logic i_wb_cyc, // bus cycle
	input wire logic i_wb_stb, // strobe
	input wire logic i_wb_we, // write enable
	input wire logic [31:0] i_wb_adr, // byte address
	input wire logic [31:0] i_wb_dat, // write data
	input wire logic [3:0] i_wb_sel, // byte lanes
	output logic o_wb_ack, // acknowledge
	output logic [31:0] o_wb_dat, // read data
	input wire logic [MODE_W-1:0] i_pinout_mode_strap, // pinout strap
	input wire logic [2:0] i_pll_multiplier_strap, // pll strap
	input wire logic i_fastboot_strap, // fast boot strap
	input wire logic i_endianness_strap, // endianness strap
	output logic [MODE_W-1:0] o_pinout_mode, // active pin select mode
	output logic [2:0] o_fastboot_pll_mult, // 0 unless fast boot
	output logic o_little_endian, // 1 little, 0 big
	output logic [PRIO_W-1:0] o_cpu_config_port_priority, // to fabric
	output logic [PRIO_W-1:0] o_host_port_priority, // to fabric
	output logic [PRIO_W-1:0] o_serial_link_priority, // to fabric
	output logic [PRIO_W-1:0] o_ethernet_priority // to fabric
);
	typedef struct packed {
		logic [MODE_W-1:0] pin_mode;
		logic [2:0] fb_mult;
		logic little;
		logic [PRIO_W-1:0] cfg;
		logic [PRIO_W-1:0] host;
		logic [PRIO_W-1:0] link;
		logic [PRIO_W-1:0] eth;
		logic [PRIO_W-1:0] rsv;
	} rsb_top_state_t;

	rsb_top_state_t state;
	rsb_top_state_t next_state;
	rsb_reg_if regs ();
	logic capture;
	logic [MODE_W-1:0] lat_mode;
	logic [2:0] lat_pll;
	logic lat_fast;
	logic lat_endian;
	logic [31:0] cfg_word;
	logic [31:0] periph_word;
	logic [31:0] boot_word;
	logic [31:0] pinsel_word;
	logic [31:0] merged;

	// ==================================================================
	// elaboration checks on the field map
	if (PRIO_W != 3 || MODE_W != 3)
	begin : g_bad_code_width
		$error("priority and pinout codes must be 3 bits"); // R9
	end
	if (RSV_PRIO_LSB + PRIO_W > 32 || CFG_PRIO_LSB + PRIO_W > 32)
	begin : g_bad_field_top
		$error("priority field runs past bit 31");
	end
	if (HOST_PRIO_LSB < LINK_PRIO_LSB + PRIO_W
		|| RSV_PRIO_LSB < HOST_PRIO_LSB + PRIO_W
		|| LINK_PRIO_LSB < ETH_PRIO_LSB + PRIO_W)
	begin : g_bad_field_order
		$error("peripheral priority fields overlap");
	end
	if (BOOT_PLL_LSB < BOOT_MODE_LSB + MODE_W
		|| BOOT_ENDIAN_BIT < BOOT_PLL_LSB + 3
		|| BOOT_FAST_BIT <= BOOT_ENDIAN_BIT
		|| BOOT_FAST_BIT > 31)
	begin : g_bad_boot_map
		$error("boot status fields overlap");
	end

	// ==================================================================
	// sub-blocks
	rsb_wb_slave u_bus (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_wb_dat(i_wb_dat),
		.i_wb_sel(i_wb_sel),
		.o_wb_ack(o_wb_ack),
		.o_wb_dat(o_wb_dat),
		.regs(regs)
	);

	rsb_strap_latch u_straps (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_pinout_mode_strap(i_pinout_mode_strap),
		.i_pll_multiplier_strap(i_pll_multiplier_strap),
		.i_fastboot_strap(i_fastboot_strap),
		.i_endianness_strap(i_endianness_strap),
		.o_capture(capture),
		.o_latched_pinout_mode(lat_mode),
		.o_pll_mult(lat_pll),
		.o_fastboot(lat_fast),
		.o_endian(lat_endian)
	);

	// ==================================================================
	// read words, reserved bits zero
	always_comb
	begin
		cfg_word = '0;
		cfg_word[CFG_PRIO_LSB +: PRIO_W] = state.cfg; // R11 R14
		periph_word = '0;
		periph_word[RSV_PRIO_LSB +: PRIO_W] = state.rsv; // R13
		periph_word[HOST_PRIO_LSB +: PRIO_W] = state.host; // R12
		periph_word[LINK_PRIO_LSB +: PRIO_W] = state.link;
		periph_word[ETH_PRIO_LSB +: PRIO_W] = state.eth; // R14
		boot_word = '0;
		boot_word[BOOT_MODE_LSB +: MODE_W] = lat_mode;
		boot_word[BOOT_PLL_LSB +: 3] = lat_pll;
		boot_word[BOOT_ENDIAN_BIT] = lat_endian;
		boot_word[BOOT_FAST_BIT] = lat_fast;
		pinsel_word = '0;
		pinsel_word[PINSEL_MODE_LSB +: MODE_W] = state.pin_mode;
	end

	// read mux, unmapped reads zero
	always_comb
	begin
		case (regs.addr)
			ADDR_CFG_PRIO: regs.rdata = cfg_word;
			ADDR_PERIPH_PRIO: regs.rdata = periph_word;
			ADDR_BOOT_STATUS: regs.rdata = boot_word;
			ADDR_PIN_SELECT: regs.rdata = pinsel_word;
			default: regs.rdata = '0;
		endcase
	end

	// byte-lane merge of write data over the current word
	for (genvar b = 0; b < 4; b++)
	begin : g_lane
		assign merged[8*b +: 8] = regs.sel[b] ? regs.wdata[8*b +: 8]
			: regs.rdata[8*b +: 8];
	end

	// ==================================================================
	// next state
	always_comb
	begin
		next_state = state;
		// pll strap matters only in fast boot
		next_state.fb_mult = lat_fast ? lat_pll : 3'h0; // R5
		next_state.little = lat_endian; // R7
		// software writes; boot status is never written
		if (regs.req && regs.we)
		begin
			case (regs.addr)
				ADDR_PIN_SELECT: next_state.pin_mode =
					merged[PINSEL_MODE_LSB +: MODE_W]; // R3
				ADDR_CFG_PRIO: next_state.cfg =
					merged[CFG_PRIO_LSB +: PRIO_W]; // R11
				ADDR_PERIPH_PRIO:
				begin
					next_state.rsv = merged[RSV_PRIO_LSB +: PRIO_W]; // R13
					next_state.host = merged[HOST_PRIO_LSB +: PRIO_W]; // R12
					next_state.link = merged[LINK_PRIO_LSB +: PRIO_W];
					next_state.eth = merged[ETH_PRIO_LSB +: PRIO_W];
				end
				default: next_state = next_state; // boot status read-only
			endcase
		end
		// strap seeds the pin select field and wins over a write
		if (capture)
		begin
			next_state.pin_mode = lat_mode_next(); // R2
		end
	end

	// strap as presented in the capture cycle
	function automatic logic [MODE_W-1:0] lat_mode_next();
		return i_pinout_mode_strap;
	endfunction : lat_mode_next

	// state register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state <= '0;
			state.cfg <= RST_CFG_PRIO; // R10
			state.host <= RST_PERIPH_PRIO; // R10
			state.link <= RST_PERIPH_PRIO;
			state.eth <= RST_PERIPH_PRIO;
			state.rsv <= RST_RSV_PRIO; // R13
		end
		else
		begin
			state <= next_state;
		end
	end

	// pinout only reaches the pin select output
	assign o_pinout_mode = state.pin_mode; // R4
	assign o_fastboot_pll_mult = state.fb_mult;
	assign o_little_endian = state.little;
	// continuous codes, lower code wins at the fabric
	assign o_cpu_config_port_priority = state.cfg; // R16 R9
	assign o_host_port_priority = state.host; // R16
	assign o_serial_link_priority = state.link;
	assign o_ethernet_priority = state.eth;

	// ==================================================================
	// checks
	chk_pinsel_seeded: assert property (@(posedge i_clock) disable iff (i_rst) // R2
		capture |=> o_pinout_mode == $past(i_pinout_mode_strap))
		else $error("pin select not seeded from strap");
	chk_pinsel_write: assert property (@(posedge i_clock) disable iff (i_rst) // R3
		(regs.req && regs.we && regs.addr == ADDR_PIN_SELECT && regs.sel[0]
			&& !capture) |=> o_pinout_mode == $past(regs.wdata[2:0]))
		else $error("pin select write lost");
	chk_boot_readonly: assert property (@(posedge i_clock) disable iff (i_rst) // R3
		(regs.req && regs.we && regs.addr == ADDR_BOOT_STATUS && !capture)
			|=> $stable(boot_word))
		else $error("boot status changed by a write");
	chk_fastboot_gate: assert property (@(posedge i_clock) disable iff (i_rst) // R5
		!lat_fast ##1 !lat_fast |-> o_fastboot_pll_mult == 3'h0)
		else $error("pll multiplier passed without fast boot");
	chk_endian_follow: assert property (@(posedge i_clock) disable iff (i_rst) // R7
		!capture ##1 1'b1 |-> o_little_endian == $past(lat_endian))
		else $error("endianness output not following strap");
	chk_prio_defaults: assert property (@(posedge i_clock) disable iff (i_rst) // R10
		$past(i_rst) |-> o_cpu_config_port_priority == 3'h1
			&& o_ethernet_priority == 3'h4 && o_host_port_priority == 3'h4
			&& o_serial_link_priority == 3'h4 && state.rsv == 3'h4)
		else $error("priority reset values wrong");
	chk_periph_write: assert property (@(posedge i_clock) disable iff (i_rst) // R12
		(regs.req && regs.we && regs.addr == ADDR_PERIPH_PRIO
			&& regs.sel == 4'hf) |=> o_ethernet_priority
			== $past(regs.wdata[2:0]) && o_host_port_priority
			== $past(regs.wdata[22:20]))
		else $error("peripheral priority write lost");
	chk_reserved_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R14
		(regs.req && regs.addr == ADDR_CFG_PRIO) |-> regs.rdata[31:11] == '0
			&& regs.rdata[7:0] == '0)
		else $error("reserved bits read nonzero");
	chk_cfg_write: assert property ( // R11
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.we && regs.addr == ADDR_CFG_PRIO && regs.sel[1])
		|=> o_cpu_config_port_priority == $past(regs.wdata[10:8]))
		else $error("config priority write lost");
	chk_link_write: assert property ( // R12
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.we && regs.addr == ADDR_PERIPH_PRIO
			&& regs.sel[2])
		|=> o_serial_link_priority == $past(regs.wdata[18:16]))
		else $error("serial link priority write lost");
	chk_eth_lane: assert property ( // R12
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.we && regs.addr == ADDR_PERIPH_PRIO
			&& regs.sel[0])
		|=> o_ethernet_priority == $past(regs.wdata[2:0]))
		else $error("ethernet priority lane write lost");
	chk_rsv_write: assert property ( // R13
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.we && regs.addr == ADDR_PERIPH_PRIO
			&& regs.sel[3])
		|=> state.rsv == $past(regs.wdata[26:24]))
		else $error("reserved priority field write lost");
	chk_periph_reserved: assert property ( // R14
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.addr == ADDR_PERIPH_PRIO)
			|-> regs.rdata[31:27] == '0 && !regs.rdata[23]
			&& !regs.rdata[19] && regs.rdata[15:3] == '0)
		else $error("peripheral reserved bits read nonzero");
	chk_boot_fields: assert property ( // R1 R6
		@(posedge i_clock) disable iff (i_rst)
		(regs.req && regs.addr == ADDR_BOOT_STATUS)
			|-> regs.rdata[2:0] == lat_mode && regs.rdata[6:4] == lat_pll
			&& regs.rdata[8] == lat_endian)
		else $error("boot status fields differ from latched straps");
	chk_pll_pass: assert property ( // R5
		@(posedge i_clock) disable iff (i_rst)
		lat_fast ##1 1'b1 |-> o_fastboot_pll_mult == $past(lat_pll))
		else $error("fast boot multiplier not passed on");
	chk_prio_hold: assert property ( // R16
		@(posedge i_clock) disable iff (i_rst)
		!(regs.req && regs.we) |=> $stable(o_cpu_config_port_priority)
			&& $stable(o_host_port_priority)
			&& $stable(o_serial_link_priority)
			&& $stable(o_ethernet_priority))
		else $error("priority code changed without a write");
endmodule : rsb_top

// File: hw/rsb_wb_slave.sv
// Purpose: classic wishbone slave, turns bus cycles into register requests
// Assumes: master holds the request until ack
// Notes: ack one cycle after stb is seen, then low for at least one cycle
`timescale 1ns/10ps
// ==========================================================================
// module
module rsb_wb_slave
	import rsb_pkg::*;
(
	input wire logic i_clock, // system clock
	input wire logic i_rst, // sync reset, active high
	input wire logic i_wb_cyc, // bus cycle
	input wire logic i_wb_stb, // strobe
	input wire logic i_wb_we, // write enable
	input wire logic [31:0] i_wb_adr, // byte address
	input wire logic [31:0] i_wb_dat, // write data
	input wire logic [3:0] i_wb_sel, // byte lanes
	output logic o_wb_ack, // acknowledge
	output logic [31:0] o_wb_dat, // read data
	rsb_reg_if.slave regs // request to the bank
);
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rsb_wb_state_t;

	rsb_wb_state_t state;
	rsb_wb_state_t next_state;
	logic take;

	// a new request is taken only while ack is low
	assign take = i_wb_cyc && i_wb_stb && !state.ack;
	assign regs.req = take;
	assign regs.we = i_wb_we;
	assign regs.addr = i_wb_adr;
	assign regs.wdata = i_wb_dat;
	assign regs.sel = i_wb_sel;

	// next state
	always_comb
	begin
		next_state = state;
		next_state.ack = take;
		if (take && !i_wb_we)
		begin
			next_state.dat = regs.rdata;
		end
	end

	// state register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign o_wb_ack = state.ack;
	assign o_wb_dat = state.dat;

	// ==================================================================
	// checks
	chk_ack_single_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held for more than one cycle");
	chk_ack_follows_stb: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("request not acknowledged next cycle");
endmodule : rsb_wb_slave
